// [core/clock_select_pkg.sv]
// Shared constants, types and helpers of the system clock select and divide block
package clock_select_pkg;

   // ------------------------------------------------------------
   // Register port addresses
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CLK_SELECT = 8'hBD;
   localparam logic [7:0] ADDR_OSC_TRIM = 8'hBF;
   localparam logic [7:0] ADDR_OSC_CONTROL = 8'hA9;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int READY_BIT = 7;
   localparam int DIV_LSB = 4;
   localparam int DIV_W = 3;
   localparam int RSVD_BIT = 3;
   localparam int SRC_LSB = 0;
   localparam int SRC_W = 3;
   localparam int CTRL_EN_BIT = 7;
   localparam int CTRL_RDY_BIT = 6;
   localparam int CTRL_SPREAD_BIT = 3;
   localparam int CTRL_PDIV_LSB = 0;
   localparam int PDIV_W = 2;
   localparam int TRIM_W = 8;

   // ------------------------------------------------------------
   // Reset values and codes
   // ------------------------------------------------------------
   localparam logic [SRC_W-1:0] SRC_INTERNAL = 3'h0;
   localparam logic [SRC_W-1:0] SRC_EXTERNAL = 3'h1;
   localparam logic [SRC_W-1:0] SRC_RESET = 3'h0;
   localparam logic [DIV_W-1:0] DIV_RESET = 3'h0;
   localparam logic [PDIV_W-1:0] PDIV_RESET = 2'h0; // Code 00 divides by 8
   localparam logic OSC_EN_RESET = 1'b1;
   localparam logic SPREAD_RESET = 1'b0;
   localparam logic [TRIM_W-1:0] TRIM_RESET = 8'h80; // Stand-in for the factory trim

   // ------------------------------------------------------------
   // Timing counts
   // ------------------------------------------------------------
   localparam int MAX_DIV_CYCLES = 128;
   localparam int SS_UPDATE_CYCLES = 32;
   localparam int SS_TRIANGLE_CYCLES = 384;
   localparam int SS_STEPS = SS_TRIANGLE_CYCLES / SS_UPDATE_CYCLES;
   localparam logic [4:0] SS_CNT_LAST = 5'(SS_UPDATE_CYCLES - 1);
   localparam logic [3:0] SS_PHASE_LAST = 4'(SS_STEPS - 1);
   localparam int CORE_CLK_KHZ = 125000;
   localparam int OSC_NOM_KHZ = 24500;
   localparam int NCO_W = 16;
   localparam logic [15:0] OSC_BASE_INC = 16'((OSC_NOM_KHZ * 65536) / CORE_CLK_KHZ);
   localparam logic [15:0] TRIM_STEP_INC = 16'h0020;
   localparam logic [15:0] OSC_FAST_INC = 16'(int'(OSC_BASE_INC) + 128 * int'(TRIM_STEP_INC));

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SW_IDLE = 2'b01,
      SW_WAIT = 2'b10
   } sw_state_t;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Terminal count of the system divider for a divide code
   function automatic logic [6:0] div_mask(input logic [2:0] code);
      div_mask = 7'h7F >> (3'h7 - code);
   endfunction : div_mask

   // Triangle level -3..+3 for a modulation phase 0..11
   function automatic logic signed [2:0] tri_level(input logic [3:0] phase);
      if (phase <= 4'h3) begin
         tri_level = 3'(phase);
      end else if (phase <= 4'h9) begin
         tri_level = 3'(4'h6 - phase);
      end else begin
         tri_level = 3'(phase - 4'hC);
      end
   endfunction : tri_level

endpackage : clock_select_pkg

// [core/sys_divider.sv]
// Power-of-two system clock divider with glitch-free divide changes
`timescale 1ns/1ps
module sys_divider
   import clock_select_pkg::*;
(
   input wire logic core_clk, // Core clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic ce, // Clock enable, freezes state when low
   input wire logic src_tick, // One undivided source cycle
   input wire logic [clock_select_pkg::DIV_W-1:0] div_code, // Requested divide code
   input wire logic div_load, // Divide setting written
   output logic sys_tick, // One divided system clock cycle
   output logic div_ready // Requested setting applied
);
   logic [6:0] cnt_ff, nxt_cnt;
   logic [6:0] mask_ff, nxt_mask;
   logic pend_ff, nxt_pend;
   logic tick_ff, nxt_tick;

   // Next state: new mask only at a period boundary, so no short pulse
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_mask = mask_ff;
      nxt_pend = pend_ff | div_load; // RULE_04
      nxt_tick = 1'b0;
      if (src_tick) begin
         if (cnt_ff >= mask_ff) begin
            nxt_cnt = 7'h00;
            nxt_tick = 1'b1; // RULE_02
            if (pend_ff) begin
               nxt_mask = div_mask(div_code); // RULE_05
               nxt_pend = div_load; // Write in the apply cycle stays pending
            end
         end else begin
            nxt_cnt = cnt_ff + 7'h01;
         end
      end
   end

   // Registers
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cnt_ff <= 7'h00;
         mask_ff <= div_mask(DIV_RESET);
         pend_ff <= 1'b0;
         tick_ff <= 1'b0;
      end else if (ce) begin
         cnt_ff <= nxt_cnt;
         mask_ff <= nxt_mask;
         pend_ff <= nxt_pend;
         tick_ff <= nxt_tick;
      end
   end

   assign sys_tick = tick_ff;
   assign div_ready = ~pend_ff;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   count_in_range_a: assert property (@(posedge core_clk) disable iff (!rst_n) cnt_ff <= mask_ff) // RULE_02
      else $error("divider count beyond terminal count");
   mask_at_boundary_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_05
      $changed(mask_ff) |-> cnt_ff == 7'h00 && tick_ff && $past(pend_ff))
      else $error("divide changed away from a period boundary");

endmodule : sys_divider

// [core/int_osc_core.sv]
// Internal oscillator model: trim, spread-spectrum modulation and post-divider
`timescale 1ns/1ps
module int_osc_core
   import clock_select_pkg::*;
(
   input wire logic core_clk, // Core clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic ce, // Clock enable, freezes state when low
   input wire logic osc_en, // Oscillator running
   input wire logic spread_spectrum_enable, // Spread spectrum on
   input wire logic [clock_select_pkg::TRIM_W-1:0] trim, // Period trim, 0 fastest
   input wire logic [clock_select_pkg::PDIV_W-1:0] pdiv, // Post-divide code
   output logic osc_tick // One post-divided oscillator cycle
);
   logic [NCO_W-1:0] acc_ff, nxt_acc;
   logic [4:0] ss_cnt_ff, nxt_ss_cnt;
   logic [3:0] phase_ff, nxt_phase;
   logic [2:0] pcnt_ff, nxt_pcnt;
   logic tick_ff, nxt_tick;
   logic [15:0] base_inc, step_inc, offs, inc;
   logic signed [2:0] level;
   logic [1:0] mag;
   logic [NCO_W:0] sum;
   logic raw;

   // Increment: trim sets the period, the triangle nudges it in 0.24 % steps
   always_comb begin
      base_inc = OSC_FAST_INC - {3'h0, trim, 5'h00}; // RULE_12
      step_inc = (base_inc >> 9) + (base_inc >> 11); // RULE_11
      level = spread_spectrum_enable ? tri_level(phase_ff) : 3'sh0; // RULE_10
      mag = level[2] ? 2'(-level) : level[1:0];
      offs = 16'(step_inc * {14'h0000, mag});
      inc = level[2] ? base_inc - offs : base_inc + offs;
      sum = {1'b0, acc_ff} + {1'b0, inc};
      raw = osc_en & sum[NCO_W]; // RULE_14
   end

   // Next state of accumulator, modulation and post-divider
   always_comb begin
      nxt_acc = osc_en ? sum[NCO_W-1:0] : acc_ff;
      nxt_ss_cnt = ss_cnt_ff;
      nxt_phase = phase_ff;
      nxt_pcnt = pcnt_ff;
      nxt_tick = 1'b0;
      if (!spread_spectrum_enable) begin
         nxt_ss_cnt = 5'h00;
         nxt_phase = 4'h0;
      end else if (raw) begin
         nxt_ss_cnt = ss_cnt_ff + 5'h01;
         if (ss_cnt_ff == SS_CNT_LAST) begin
            nxt_ss_cnt = 5'h00; // RULE_11
            nxt_phase = (phase_ff == SS_PHASE_LAST) ? 4'h0 : phase_ff + 4'h1; // RULE_10
         end
      end
      if (raw) begin
         if (pcnt_ff >= (3'h7 >> pdiv)) begin
            nxt_pcnt = 3'h0;
            nxt_tick = 1'b1; // RULE_09
         end else begin
            nxt_pcnt = pcnt_ff + 3'h1;
         end
      end
   end

   // Registers
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         acc_ff <= '0;
         ss_cnt_ff <= 5'h00;
         phase_ff <= 4'h0;
         pcnt_ff <= 3'h0;
         tick_ff <= 1'b0;
      end else if (ce) begin
         acc_ff <= nxt_acc;
         ss_cnt_ff <= nxt_ss_cnt;
         phase_ff <= nxt_phase;
         pcnt_ff <= nxt_pcnt;
         tick_ff <= nxt_tick;
      end
   end

   assign osc_tick = tick_ff;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   ss_step_period_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_11
      $changed(phase_ff) && $past(spread_spectrum_enable) |-> $past(ss_cnt_ff) == SS_CNT_LAST && $past(raw))
      else $error("modulation step not after 32 oscillator cycles");
   ss_phase_range_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_10
      phase_ff <= SS_PHASE_LAST)
      else $error("modulation phase outside triangle");
   osc_off_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_14
      ce && !osc_en |=> !osc_tick)
      else $error("disabled oscillator still ticking");

endmodule : int_osc_core

// [core/system_clock_select_divide.sv]
// System clock source select, divider and internal oscillator control registers
//
// Behaviour
// (RULE_01) Source field code 000 picks the internal oscillator, 001 the external one, others are reserved.
// (RULE_02) The selected source is divided by 1, 2, 4 ... 128 for divide codes 000 to 111.
// (RULE_03) A new divide value takes effect within 128 cycles of the undivided source.
// (RULE_04) Bit 7 of the clock select register reads 0 while a divide change is pending and 1 once applied.
// (RULE_05) A new divide value is applied only at a period boundary, the ready bit staying low until then.
// (RULE_06) Software sets divide by one before entering suspend.
// (RULE_07) The source may change while running and takes over after one period of the slower oscillator.
// (RULE_08) After reset the system runs from the internal oscillator.
// (RULE_09) The internal oscillator is post-divided by 1, 2, 4 or 8, defaulting to 8.
// (RULE_10) Spread spectrum modulates the oscillator with a stepped triangle of period 384 oscillator cycles.
// (RULE_11) Modulation steps every 32 oscillator cycles, about 0.25 % each, within plus or minus 0.75 %.
// (RULE_12) The trim register sets the oscillator period, all zeros fastest, all ones slowest.
// (RULE_13) Bit 3 of the clock select register reads zero and software writes zero there.
// (RULE_14) Bit 7 of the oscillator control register enables the internal oscillator and resets to one.
`timescale 1ns/1ps
module system_clock_select_divide
   import clock_select_pkg::*;
#(
   parameter logic [clock_select_pkg::TRIM_W-1:0] TRIM_INIT = clock_select_pkg::TRIM_RESET // Calibrated trim
)(
   input wire logic core_clk, // Core clock, 125 MHz
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic ce, // Clock enable, freezes state when low
   input wire logic [7:0] sfr_addr, // Register address
   input wire logic sfr_wr, // Register write strobe
   input wire logic sfr_rd, // Register read strobe
   input wire logic [7:0] sfr_wdata, // Register write data
   output logic [7:0] sfr_rdata, // Register read data, one cycle after strobe
   input wire logic ext_osc_in, // External oscillator pin
   output logic sys_clk_en, // One system clock cycle
   output logic sys_src_ext // System running from external oscillator
);
   import clock_select_pkg::*;

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   logic [DIV_W-1:0] div_code_ff, nxt_div_code;
   logic [SRC_W-1:0] src_code_ff, nxt_src_code;
   logic [TRIM_W-1:0] trim_ff, nxt_trim;
   logic osc_en_ff, nxt_osc_en;
   logic spread_en_ff, nxt_spread_en;
   logic [PDIV_W-1:0] pdiv_ff, nxt_pdiv;
   logic [7:0] rdata_ff, nxt_rdata;
   logic wr_sel, wr_trim, wr_ctrl;
   logic div_ready, div_tick;

   // Write decode, gated by clock enable so a frozen block takes no writes
   assign wr_sel = ce & sfr_wr & (sfr_addr == ADDR_CLK_SELECT);
   assign wr_trim = ce & sfr_wr & (sfr_addr == ADDR_OSC_TRIM);
   assign wr_ctrl = ce & sfr_wr & (sfr_addr == ADDR_OSC_CONTROL);

   // Next register values and read mux
   always_comb begin
      nxt_div_code = div_code_ff;
      nxt_src_code = src_code_ff;
      nxt_trim = trim_ff;
      nxt_osc_en = osc_en_ff;
      nxt_spread_en = spread_en_ff;
      nxt_pdiv = pdiv_ff;
      if (wr_sel) begin
         nxt_div_code = sfr_wdata[DIV_LSB +: DIV_W]; // RULE_02
         nxt_src_code = sfr_wdata[SRC_LSB +: SRC_W]; // RULE_01
      end
      if (wr_trim) begin
         nxt_trim = sfr_wdata; // RULE_12
      end
      if (wr_ctrl) begin
         nxt_osc_en = sfr_wdata[CTRL_EN_BIT]; // RULE_14
         nxt_spread_en = sfr_wdata[CTRL_SPREAD_BIT]; // RULE_10
         nxt_pdiv = sfr_wdata[CTRL_PDIV_LSB +: PDIV_W]; // RULE_09
      end
      nxt_rdata = rdata_ff;
      if (sfr_rd) begin
         nxt_rdata = 8'h00; // Unmapped addresses and reserved bits read zero
         case (sfr_addr)
            ADDR_CLK_SELECT: begin
               nxt_rdata[READY_BIT] = div_ready; // RULE_04
               nxt_rdata[DIV_LSB +: DIV_W] = div_code_ff;
               nxt_rdata[RSVD_BIT] = 1'b0; // RULE_13
               nxt_rdata[SRC_LSB +: SRC_W] = src_code_ff;
            end
            ADDR_OSC_TRIM: begin
               nxt_rdata = trim_ff;
            end
            ADDR_OSC_CONTROL: begin
               nxt_rdata[CTRL_EN_BIT] = osc_en_ff;
               nxt_rdata[CTRL_RDY_BIT] = osc_en_ff; // Model oscillator is ready once on
               nxt_rdata[CTRL_SPREAD_BIT] = spread_en_ff;
               nxt_rdata[CTRL_PDIV_LSB +: PDIV_W] = pdiv_ff;
            end
            default: begin
               nxt_rdata = 8'h00;
            end
         endcase
      end
   end

   // Register file flops
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         div_code_ff <= DIV_RESET;
         src_code_ff <= SRC_RESET; // RULE_08
         trim_ff <= TRIM_INIT;
         osc_en_ff <= OSC_EN_RESET; // RULE_14
         spread_en_ff <= SPREAD_RESET;
         pdiv_ff <= PDIV_RESET; // RULE_09
         rdata_ff <= 8'h00;
      end else if (ce) begin
         div_code_ff <= nxt_div_code;
         src_code_ff <= nxt_src_code;
         trim_ff <= nxt_trim;
         osc_en_ff <= nxt_osc_en;
         spread_en_ff <= nxt_spread_en;
         pdiv_ff <= nxt_pdiv;
         rdata_ff <= nxt_rdata;
      end
   end

   assign sfr_rdata = rdata_ff;

   // ------------------------------------------------------------
   // External oscillator synchroniser and edge detect
   // ------------------------------------------------------------
   logic ext_s1_ff, ext_s2_ff, ext_s3_ff;
   logic ext_tick, int_tick;

   // Pin is asynchronous; only the second and third stages feed the edge detector
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ext_s1_ff <= 1'b0;
         ext_s2_ff <= 1'b0;
         ext_s3_ff <= 1'b0;
      end else if (ce) begin
         ext_s1_ff <= ext_osc_in;
         ext_s2_ff <= ext_s1_ff;
         ext_s3_ff <= ext_s2_ff;
      end
   end

   assign ext_tick = ext_s2_ff & ~ext_s3_ff;

   // ------------------------------------------------------------
   // Internal oscillator
   // ------------------------------------------------------------
   int_osc_core u_int_osc (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .ce(ce),
      .osc_en(osc_en_ff),
      .spread_spectrum_enable(spread_en_ff),
      .trim(trim_ff),
      .pdiv(pdiv_ff),
      .osc_tick(int_tick)
   );

   // ------------------------------------------------------------
   // On-the-fly source switch
   // ------------------------------------------------------------
   sw_state_t sw_state_ff, nxt_sw_state;
   logic active_ext_ff, nxt_active_ext;
   logic seen_old_ff, nxt_seen_old;
   logic seen_new_ff, nxt_seen_new;
   logic want_ext, want_valid, src_tick, old_tick, new_tick;

   // Reserved source codes leave the running source in place
   assign want_valid = (src_code_ff == SRC_INTERNAL) || (src_code_ff == SRC_EXTERNAL); // RULE_01
   assign want_ext = (src_code_ff == SRC_EXTERNAL);
   assign old_tick = active_ext_ff ? ext_tick : int_tick;
   assign new_tick = active_ext_ff ? int_tick : ext_tick;
   assign src_tick = old_tick;

   // Switch waits for a full cycle of both sources, which covers the slower one
   always_comb begin
      nxt_sw_state = sw_state_ff;
      nxt_active_ext = active_ext_ff;
      nxt_seen_old = seen_old_ff;
      nxt_seen_new = seen_new_ff;
      case (sw_state_ff)
         SW_IDLE: begin
            nxt_seen_old = 1'b0;
            nxt_seen_new = 1'b0;
            if (want_valid && (want_ext != active_ext_ff)) begin
               nxt_sw_state = SW_WAIT;
            end
         end
         SW_WAIT: begin
            nxt_seen_old = seen_old_ff | old_tick;
            nxt_seen_new = seen_new_ff | new_tick;
            if (!want_valid || (want_ext == active_ext_ff)) begin
               nxt_sw_state = SW_IDLE;
            end else if (seen_old_ff && seen_new_ff) begin
               nxt_active_ext = want_ext; // RULE_07
               nxt_sw_state = SW_IDLE;
            end
         end
         default: begin
            nxt_sw_state = SW_IDLE;
         end
      endcase
   end

   // Switch flops
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sw_state_ff <= SW_IDLE;
         active_ext_ff <= 1'b0; // RULE_08
         seen_old_ff <= 1'b0;
         seen_new_ff <= 1'b0;
      end else if (ce) begin
         sw_state_ff <= nxt_sw_state;
         active_ext_ff <= nxt_active_ext;
         seen_old_ff <= nxt_seen_old;
         seen_new_ff <= nxt_seen_new;
      end
   end

   assign sys_src_ext = active_ext_ff;

   // ------------------------------------------------------------
   // System divider
   // ------------------------------------------------------------
   sys_divider u_divider (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .ce(ce),
      .src_tick(src_tick),
      .div_code(div_code_ff),
      .div_load(wr_sel),
      .sys_tick(div_tick),
      .div_ready(div_ready)
   );

   assign sys_clk_en = div_tick;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   logic [7:0] pend_ticks_ff;

   // Source cycles seen since the last divide write while still pending
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pend_ticks_ff <= 8'h00;
      end else if (ce) begin
         if (wr_sel || div_ready) begin
            pend_ticks_ff <= 8'h00;
         end else if (src_tick && pend_ticks_ff != 8'hFF) begin
            pend_ticks_ff <= pend_ticks_ff + 8'h01;
         end
      end
   end

   div_apply_bound_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_03
      pend_ticks_ff <= 8'(MAX_DIV_CYCLES))
      else $error("divide change took more than 128 source cycles");
   ready_low_write_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_04
      wr_sel |=> !div_ready)
      else $error("ready flag high right after divide write");
   rsvd_bit_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_13
      ce && sfr_rd && sfr_addr == ADDR_CLK_SELECT |=> sfr_rdata[RSVD_BIT] == 1'b0
         && sfr_rdata[READY_BIT] == $past(div_ready))
      else $error("clock select read back wrong");
   reset_state_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_08
      $rose(rst_n) |-> !sys_src_ext && osc_en_ff && pdiv_ff == PDIV_RESET && div_code_ff == DIV_RESET)
      else $error("wrong state after reset");
   switch_after_both_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_07
      $changed(active_ext_ff) |-> $past(seen_old_ff) && $past(seen_new_ff) && active_ext_ff == $past(want_ext))
      else $error("source switched before both oscillators cycled");
   reserved_src_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_01
      !want_valid && ce |=> $stable(active_ext_ff))
      else $error("reserved source code changed the source");
   // Write and read are split so that any spacing between them is covered
   trim_write_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_12
      wr_trim |=> trim_ff == $past(sfr_wdata))
      else $error("trim register did not take written value");
   trim_readback_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_12
      ce && sfr_rd && sfr_addr == ADDR_OSC_TRIM |=> sfr_rdata == $past(trim_ff))
      else $error("trim register read back wrong");
   osc_en_write_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_14
      wr_ctrl |=> osc_en_ff == $past(sfr_wdata[CTRL_EN_BIT]))
      else $error("oscillator enable not taken from write");

   // Field readback and apply timing
   ready_at_tick_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_05
      $rose(div_ready) |-> div_tick)
      else $error("divide applied away from a system clock edge");
   sel_readback_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_02
      ce && sfr_rd && sfr_addr == ADDR_CLK_SELECT |=> sfr_rdata[DIV_LSB +: DIV_W] == $past(div_code_ff)
         && sfr_rdata[SRC_LSB +: SRC_W] == $past(src_code_ff))
      else $error("clock select fields read back wrong");
   pdiv_readback_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_09
      ce && sfr_rd && sfr_addr == ADDR_OSC_CONTROL |=> sfr_rdata[CTRL_PDIV_LSB +: PDIV_W] == $past(pdiv_ff))
      else $error("post-divide field read back wrong");

   // Main scenarios: both switch directions, divide apply, write at apply, frozen write
   switch_ext_c: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(active_ext_ff));
   switch_int_c: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(active_ext_ff));
   div_applied_c: cover property (@(posedge core_clk) disable iff (!rst_n) !div_ready ##1 div_ready);
   write_at_apply_c: cover property (@(posedge core_clk) disable iff (!rst_n) wr_sel && div_tick);
   ce_freeze_c: cover property (@(posedge core_clk) disable iff (!rst_n) !ce && sfr_wr);

endmodule : system_clock_select_divide

// [bench/system_clock_select_divide_tb.sv]
// Self-checking bench of the system clock select and divide block
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module system_clock_select_divide_tb;
   import clock_select_pkg::*;
   logic core_clk = 0, rst_n = 0, ce = 1, sfr_wr = 0, sfr_rd = 0, ext_osc_in = 0, ext_run = 1, sys_clk_en, sys_src_ext;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, v, mdl_sel, mdl_trim;
   int n_errors = 0, n_checks = 0, ph = 0, d, d0, g, k;
   // ----
   // Clocks and design
   // ----
   always #4 core_clk = ~core_clk;
   // External source: one rise every 8 core cycles, frozen to hold off divider boundaries
   always @(negedge core_clk) begin
      if (ext_run) begin
         ph = (ph + 1) % 8;
         ext_osc_in <= (ph < 4);
      end
   end
   system_clock_select_divide dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .ext_osc_in(ext_osc_in), .sys_clk_en(sys_clk_en), .sys_src_ext(sys_src_ext));
   // ----
   // Register port tasks
   // ----
   task automatic wr(input logic [7:0] a, input logic [7:0] w);
      @(negedge core_clk);
      sfr_wr <= 1'b1;
      sfr_addr <= a;
      sfr_wdata <= w;
      @(negedge core_clk);
      sfr_wr <= 1'b0;
   endtask : wr
   // Read data lands one edge after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] r);
      @(negedge core_clk);
      sfr_rd <= 1'b1;
      sfr_addr <= a;
      @(negedge core_clk);
      sfr_rd <= 1'b0;
      r = sfr_rdata;
   endtask : rd
   // Poll ready; 560 polls cover 128 source ticks plus sync delay
   task automatic rdy(input logic [7:0] e);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 560 && r[7] !== 1'b1; i++) rd(ADDR_CLK_SELECT, r);
      `CHK(r, e)
   endtask : rdy
   // Wait for the source-select output to reach a level, bounded
   task automatic src_wait(input logic e);
      for (k = 0; k < 400 && sys_src_ext !== e; k++) @(negedge core_clk);
      `CHK(sys_src_ext, e)
   endtask : src_wait
   // Cycles between two system clock pulses
   task automatic gap(output int c);
      for (c = 0; c < 3000 && sys_clk_en !== 1'b1; c++) @(negedge core_clk);
      @(negedge core_clk);
      for (c = 1; c < 3000 && sys_clk_en !== 1'b1; c++) @(negedge core_clk);
   endtask : gap
   // System clock pulses in 4096 core cycles
   task automatic cnt(output int c);
      c = 0;
      repeat (4096) begin
         @(negedge core_clk);
         c += int'(sys_clk_en);
      end
   endtask : cnt
   task automatic print_verdict;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   // Watchdog well beyond the expected run length
   initial begin
      #640000;
      n_errors++;
      print_verdict();
   end
   // ----
   // Main sequence
   // ----
   initial begin
      void'($urandom(16873));
      repeat (16) @(negedge core_clk);
      rst_n <= 1'b1;
      rd(ADDR_CLK_SELECT, v);
      `CHK(v, 8'h80)
      `CHK(sys_src_ext, 1'b0)
      rd(ADDR_OSC_CONTROL, v);
      `CHK(v, 8'hC0)
      rd(ADDR_OSC_TRIM, v);
      `CHK(v, TRIM_RESET)
      rd(8'h55, v);
      `CHK(v, 8'h00)
      // Every post-divide code, then spread spectrum and a disable
      for (d = 0; d < 4; d++) begin
         wr(ADDR_OSC_CONTROL, 8'h80 | 8'(d));
         rd(ADDR_OSC_CONTROL, v);
         `CHK(v, 8'hC0 | 8'(d))
      end
      wr(ADDR_OSC_CONTROL, 8'h8B);
      rd(ADDR_OSC_CONTROL, v);
      `CHK(v, 8'hCB)
      wr(ADDR_OSC_CONTROL, 8'h03);
      rd(ADDR_OSC_CONTROL, v);
      `CHK(v, 8'h03)
      wr(ADDR_OSC_CONTROL, 8'h83);
      mdl_trim = 8'($urandom);
      wr(ADDR_OSC_TRIM, mdl_trim);
      rd(ADDR_OSC_TRIM, v);
      `CHK(v, mdl_trim)
      // A write while the clock enable is low must not land
      ce <= 1'b0;
      wr(ADDR_OSC_TRIM, ~mdl_trim);
      ce <= 1'b1;
      rd(ADDR_OSC_TRIM, v);
      `CHK(v, mdl_trim)
      wr(ADDR_CLK_SELECT, 8'h01);
      src_wait(1'b1);
      rdy(8'h81);
      // Reserved source code is stored but keeps the running source
      wr(ADDR_CLK_SELECT, 8'h02);
      rdy(8'h82);
      `CHK(sys_src_ext, 1'b1)
      wr(ADDR_CLK_SELECT, 8'h01);
      rdy(8'h81);
      // All divide codes from a random start; source frozen so the flag must stay low
      d0 = int'($urandom % 8);
      for (int i = 0; i < 8; i++) begin
         d = (d0 + i) % 8;
         ext_run = 1'b0;
         repeat (4) @(negedge core_clk);
         mdl_sel = {1'b0, 3'(d), 4'h1};
         wr(ADDR_CLK_SELECT, mdl_sel);
         rd(ADDR_CLK_SELECT, v);
         `CHK(v, mdl_sel)
         ext_run = 1'b1;
         rdy(mdl_sel | 8'h80);
         gap(g);
         `CHK(g, 8 << d)
      end
      wr(ADDR_CLK_SELECT, 8'h00);
      src_wait(1'b0);
      // Second reset in mid-run, taken while already on the internal source, keeps it
      rst_n <= 1'b0;
      repeat (2) @(negedge core_clk);
      rst_n <= 1'b1;
      rd(ADDR_CLK_SELECT, v);
      `CHK(v, 8'h80)
      `CHK(sys_src_ext, 1'b0)
      // Pulse counts on the internal source: post-divide, spread spectrum, trim
      cnt(k);
      wr(ADDR_OSC_CONTROL, 8'h83);
      cnt(d);
      `CHK(d >= 8 * k - 24 && d <= 8 * k + 24, 1'b1)
      wr(ADDR_OSC_CONTROL, 8'h8B);
      cnt(g);
      `CHK(g >= d - 12 && g <= d + 12, 1'b1)
      wr(ADDR_OSC_TRIM, 8'hFF);
      cnt(d0);
      `CHK(d0 < g, 1'b1)
      print_verdict();
   end
endmodule : system_clock_select_divide_tb
